// *** logic/adc_trig_pkg.sv ***
// Constants, types and helpers shared by the converter trigger and input-disable logic.
//
// Functional notes
// RULE_01 - Auto mode: source field bits 2:0 pick trigger.
// RULE_02 - Auto off: source field ignored entirely.
// RULE_03 - Conversion starts on selected flag rising edge.
// RULE_04 - Switching low source to high source is edge.
// RULE_05 - Switch edge starts only with converter enabled.
// RULE_06 - Switching to free running never triggers.
// RULE_07 - Source codes 000 to 110 as encoded below.
// RULE_08 - Trigger register bits 7, 5:3 read zero.
// RULE_09 - Disable bits 5:2 turn off channel buffers.
// RULE_10 - Disabled pin reads zero on port input.
// RULE_11 - Software disables unused analog pin buffers.
// RULE_12 - Disable register at 0x14, fixed bit map.
// RULE_13 - Auto-trigger enable bit allows edge starts.
// RULE_14 - Done flag sets when result registers updated.
// RULE_15 - Free running needs one software start write.
// RULE_16 - Edges by one-cycle compare; code 111 idle.
package adc_trig_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry and offsets.
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_TRIG_CTRL = 8'h03;
  localparam logic [7:0] OFF_RESULT_LO = 8'h04;
  localparam logic [7:0] OFF_RESULT_HI = 8'h05;
  localparam logic [7:0] OFF_CTRL_A = 8'h06;
  localparam logic [7:0] OFF_INPUT_DIS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------
  localparam int TRIG_SRC_LSB = 0;
  localparam int TRIG_SRC_W = 3;
  localparam int TRIG_MUXEN_BIT = 6;
  localparam int CA_ENABLE_BIT = 7;
  localparam int CA_START_BIT = 6;
  localparam int CA_AUTO_BIT = 5;
  localparam int CA_DONE_BIT = 4;
  localparam int CA_IRQEN_BIT = 3;
  localparam int CA_PRESC_LSB = 0;
  localparam int CA_PRESC_W = 3;
  localparam int DIS_W = 6;
  localparam int RESULT_W = 10;
  localparam logic [7:0] TRIG_CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [5:0] INPUT_DIS_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Conversion timing, in converter clock periods.
  // ----------------------------------------------------------------
  localparam logic [4:0] CONV_CYCLES_NORMAL = 5'h0d;
  localparam logic [4:0] CONV_CYCLES_FIRST = 5'h19;
  localparam int PRESC_CNT_W = 7;

  // Trigger source encoding of the source field.
  typedef enum logic [2:0] {
    SRC_FREE_RUN = 3'h0,
    SRC_COMPARATOR = 3'h1,
    SRC_EXT_INT0 = 3'h2,
    SRC_TIMER_CMP_A = 3'h3,
    SRC_TIMER_OVF = 3'h4,
    SRC_TIMER_CMP_B = 3'h5,
    SRC_PIN_CHANGE = 3'h6,
    SRC_UNUSED = 3'h7
  } trig_src_t;

  // Conversion sequencer states, Gray coded along idle, convert, finish.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONVERT = 2'h1,
    ST_FINISH = 2'h3
  } conv_state_t;

  // Terminal count of the prescaler for a select value (division minus one).
  function automatic logic [PRESC_CNT_W-1:0] prescTerminal(input logic [2:0] sel);
    logic [PRESC_CNT_W-1:0] t;
    t = 7'h00;
    case (sel)
      3'h0: t = 7'h01;
      3'h1: t = 7'h01;
      3'h2: t = 7'h03;
      3'h3: t = 7'h07;
      3'h4: t = 7'h0f;
      3'h5: t = 7'h1f;
      3'h6: t = 7'h3f;
      default: t = 7'h7f;
    endcase
    return t;
  endfunction

endpackage

// *** logic/trig_if.sv ***
// Interface between the register side and the trigger edge selector.
`timescale 1ns/1ps
interface trig_if;
  import adc_trig_pkg::*;
  trig_src_t srcSel;
  logic [7:0] flags;
  logic autoEnable;
  logic convEnable;
  logic trigStart;

  modport ctrl (output srcSel, output flags, output autoEnable, output convEnable,
                input trigStart);
  modport sel (input srcSel, input flags, input autoEnable, input convEnable,
               output trigStart);
endinterface

// *** logic/adc_trigger_select.sv ***
// Trigger source multiplexer and rising-edge detector.
`timescale 1ns/1ps
module adc_trigger_select (
  input wire logic mclk,
  input wire logic resetn,
  trig_if.sel trig
);
  import adc_trig_pkg::*;

  logic selNow;
  logic prevSel_q;
  trig_src_t prevSrc_q;
  logic toFreeRun;
  logic risingEdge;

  // Pick the flag of the selected source; the spare code gives nothing.
  always_comb begin
    if (trig.srcSel == SRC_UNUSED) begin
      selNow = 1'b0; // [RULE_16]
    end else begin
      selNow = trig.flags[trig.srcSel]; // [RULE_01] [RULE_07]
    end
  end

  // Remember last cycle's selected level and source code.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prevSel_q <= 1'b0;
      prevSrc_q <= SRC_FREE_RUN;
    end else begin
      prevSel_q <= selNow; // [RULE_16]
      prevSrc_q <= trig.srcSel;
    end
  end

  // A change of source is compared like any other edge, so moving from a low
  // flag onto a high one fires, except a move into free running.
  assign toFreeRun = (trig.srcSel == SRC_FREE_RUN) && (prevSrc_q != SRC_FREE_RUN); // [RULE_06]
  assign risingEdge = selNow && !prevSel_q && !toFreeRun; // [RULE_03] [RULE_04]

  // Edges count only with auto mode and the converter both on.
  assign trig.trigStart = trig.autoEnable && trig.convEnable && risingEdge; // [RULE_02] [RULE_05] [RULE_13]

endmodule // adc_trigger_select

// *** logic/adc_auto_trigger.sv ***
// Converter control: registers, trigger start, conversion sequencing and input disable.
`timescale 1ns/1ps
module adc_auto_trigger (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [adc_trig_pkg::ADDR_W-1:0] regAddr,
  input wire logic [adc_trig_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [adc_trig_pkg::DATA_W-1:0] regRdata,
  input wire logic comparatorFlag,
  input wire logic extInt0Flag,
  input wire logic timerCmpAFlag,
  input wire logic timerOvfFlag,
  input wire logic timerCmpBFlag,
  input wire logic pinChangeFlag,
  input wire logic [adc_trig_pkg::RESULT_W-1:0] conversionResult,
  input wire logic [adc_trig_pkg::DIS_W-1:0] pinIn,
  output logic [adc_trig_pkg::DIS_W-1:0] pinRead,
  output logic [adc_trig_pkg::DIS_W-1:0] inputBufferOff,
  output logic comparatorMuxEnable,
  output logic converterEnable,
  output logic conversionStart,
  output logic conversionBusy,
  output logic conversionDoneFlag
);
  import adc_trig_pkg::*;

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  trig_if trig ();

  trig_src_t trigSrc_q;
  logic muxEnable_q;
  logic enable_q;
  logic autoEnable_q;
  logic doneFlag_q;
  logic doneFlag_d;
  logic irqEnable_q;
  logic [CA_PRESC_W-1:0] presc_q;
  logic [DIS_W-1:0] inputDis_q;
  logic [DIS_W-1:0] pinRead_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [RESULT_W-1:0] result_q;
  conv_state_t state_q;
  conv_state_t state_d;
  logic [PRESC_CNT_W-1:0] prescCnt_q;
  logic adcTick;
  logic [4:0] convCnt_q;
  logic [4:0] convLen_q;
  logic initDone_q;
  logic startPulse_q;
  logic wrTrig;
  logic wrCtrlA;
  logic wrInputDis;
  logic swStart;
  logic startReq;
  logic clearDone;
  logic convEnd;

  // ----------------------------------------------------------------
  // Address decode for writes.
  // ----------------------------------------------------------------

  // A write touches exactly one register; unmapped addresses are dropped.
  assign wrTrig = regWrite && (regAddr == OFF_TRIG_CTRL);
  assign wrCtrlA = regWrite && (regAddr == OFF_CTRL_A);
  assign wrInputDis = regWrite && (regAddr == OFF_INPUT_DIS);

  // ----------------------------------------------------------------
  // Trigger control register.
  // ----------------------------------------------------------------

  // Only the mux enable and source field store; the other bits have no flops.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trigSrc_q <= trig_src_t'(TRIG_CTRL_RESET[TRIG_SRC_LSB +: TRIG_SRC_W]);
      muxEnable_q <= TRIG_CTRL_RESET[TRIG_MUXEN_BIT];
    end else if (wrTrig) begin
      trigSrc_q <= trig_src_t'(regWdata[TRIG_SRC_LSB +: TRIG_SRC_W]); // [RULE_01]
      muxEnable_q <= regWdata[TRIG_MUXEN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Control register A: enable, auto mode, interrupt enable, prescaler.
  // ----------------------------------------------------------------

  // Plain read/write fields of control register A.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= CTRL_A_RESET[CA_ENABLE_BIT];
      autoEnable_q <= CTRL_A_RESET[CA_AUTO_BIT];
      irqEnable_q <= CTRL_A_RESET[CA_IRQEN_BIT];
      presc_q <= CTRL_A_RESET[CA_PRESC_LSB +: CA_PRESC_W];
    end else if (wrCtrlA) begin
      enable_q <= regWdata[CA_ENABLE_BIT];
      autoEnable_q <= regWdata[CA_AUTO_BIT]; // [RULE_13]
      irqEnable_q <= regWdata[CA_IRQEN_BIT];
      presc_q <= regWdata[CA_PRESC_LSB +: CA_PRESC_W];
    end
  end

  // Writing one to the start bit asks for a conversion; zero does nothing.
  // The start is honoured when the same write also sets the enable.
  assign swStart = wrCtrlA && regWdata[CA_START_BIT] && regWdata[CA_ENABLE_BIT]; // [RULE_15]

  // The done flag clears by writing one to it.
  assign clearDone = wrCtrlA && regWdata[CA_DONE_BIT];

  // Set wins over clear, so a conversion ending during a clear is not lost.
  always_comb begin
    doneFlag_d = doneFlag_q;
    if (clearDone) begin
      doneFlag_d = 1'b0;
    end
    if (convEnd) begin
      doneFlag_d = 1'b1; // [RULE_14]
    end
  end

  // Conversion-complete flag storage.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      doneFlag_q <= CTRL_A_RESET[CA_DONE_BIT];
    end else begin
      doneFlag_q <= doneFlag_d;
    end
  end

  // ----------------------------------------------------------------
  // Input disable register and port input masking.
  // ----------------------------------------------------------------

  // Bits 5:2 are the analog channels, 1:0 the comparator inputs. Each bit
  // already lines up with the port pin it serves, so no remap is needed.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      inputDis_q <= INPUT_DIS_RESET;
    end else if (wrInputDis) begin
      inputDis_q <= regWdata[DIS_W-1:0]; // [RULE_09] [RULE_12]
    end
  end

  // A disabled buffer forces its port read bit to zero. Registered, so a
  // newly set disable bit reaches the port read one cycle after the write.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinRead_q <= '0;
    end else begin
      pinRead_q <= pinIn & ~inputDis_q; // [RULE_10]
    end
  end

  // ----------------------------------------------------------------
  // Trigger selection.
  // ----------------------------------------------------------------

  // Source zero watches our own done flag, which is what makes free running
  // restart itself once the first conversion has completed.
  assign trig.srcSel = trigSrc_q;
  assign trig.flags = {1'b0, pinChangeFlag, timerCmpBFlag, timerOvfFlag,
                       timerCmpAFlag, extInt0Flag, comparatorFlag,
                       doneFlag_q}; // [RULE_07]
  assign trig.autoEnable = autoEnable_q; // [RULE_02]
  assign trig.convEnable = enable_q; // [RULE_05]

  adc_trigger_select u_select (
    .mclk(mclk),
    .resetn(resetn),
    .trig(trig.sel)
  );

  // A request arriving while a conversion runs is dropped, as the analog
  // core cannot take a second one; software sees this only as a missed start.
  assign startReq = (swStart || trig.trigStart) && (state_q == ST_IDLE);

  // ----------------------------------------------------------------
  // Converter clock prescaler.
  // ----------------------------------------------------------------

  // Free-running divider; it holds in reset while the converter is off so
  // that the first conversion always begins on a full converter period.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prescCnt_q <= '0;
    end else if (!enable_q || startReq || adcTick) begin
      prescCnt_q <= '0;
    end else begin
      prescCnt_q <= prescCnt_q + 7'h01;
    end
  end

  assign adcTick = (state_q == ST_CONVERT) && (prescCnt_q == prescTerminal(presc_q));

  // ----------------------------------------------------------------
  // Conversion sequencer.
  // ----------------------------------------------------------------

  // Next state: start from idle, count converter periods, finish for one cycle.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (startReq) begin
          state_d = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (!enable_q) begin
          state_d = ST_IDLE;
        end else if (adcTick && (convCnt_q == convLen_q - 5'h01)) begin
          state_d = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Clearing the enable aborts a running conversion without a result.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Count converter periods within one conversion.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      convCnt_q <= '0;
    end else if (startReq) begin
      convCnt_q <= '0;
    end else if (adcTick) begin
      convCnt_q <= convCnt_q + 5'h01;
    end
  end

  // The first conversion after enabling also initialises the analog core, so the first
  // start with the enable already on gets the longer length and later ones the normal;
  // a start made by the enabling write itself keeps the previous length.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      convLen_q <= CONV_CYCLES_NORMAL;
      initDone_q <= 1'b0;
    end else if (!enable_q) begin
      initDone_q <= 1'b0;
    end else if (startReq) begin
      convLen_q <= initDone_q ? CONV_CYCLES_NORMAL : CONV_CYCLES_FIRST;
      initDone_q <= 1'b1;
    end
  end

  // One-cycle start strobe toward the analog core.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      startPulse_q <= 1'b0;
    end else begin
      startPulse_q <= startReq;
    end
  end

  // The result is captured before the flag rises, so a reader woken by the
  // flag always finds the new value.
  assign convEnd = (state_q == ST_FINISH);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      result_q <= '0;
    end else if (state_d == ST_FINISH && state_q == ST_CONVERT) begin
      result_q <= conversionResult; // [RULE_14]
    end
  end

  // ----------------------------------------------------------------
  // Register read path.
  // ----------------------------------------------------------------

  // Read data stands one cycle after the strobe and returns to zero after.
  always_comb begin
    rdata_d = '0;
    if (regRead) begin
      case (regAddr)
        OFF_TRIG_CTRL: begin
          rdata_d[TRIG_SRC_LSB +: TRIG_SRC_W] = trigSrc_q; // [RULE_08]
          rdata_d[TRIG_MUXEN_BIT] = muxEnable_q;
        end
        OFF_CTRL_A: begin
          rdata_d[CA_ENABLE_BIT] = enable_q;
          rdata_d[CA_START_BIT] = (state_q != ST_IDLE);
          rdata_d[CA_AUTO_BIT] = autoEnable_q;
          rdata_d[CA_DONE_BIT] = doneFlag_q;
          rdata_d[CA_IRQEN_BIT] = irqEnable_q;
          rdata_d[CA_PRESC_LSB +: CA_PRESC_W] = presc_q;
        end
        OFF_RESULT_LO: begin
          rdata_d = result_q[7:0];
        end
        OFF_RESULT_HI: begin
          rdata_d[1:0] = result_q[RESULT_W-1:8];
        end
        OFF_INPUT_DIS: begin
          rdata_d[DIS_W-1:0] = inputDis_q; // [RULE_12]
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------

  assign regRdata = rdata_q;
  assign pinRead = pinRead_q;
  assign inputBufferOff = inputDis_q; // [RULE_09]
  assign comparatorMuxEnable = muxEnable_q;
  assign converterEnable = enable_q;
  assign conversionStart = startPulse_q;
  assign conversionBusy = (state_q != ST_IDLE);
  assign conversionDoneFlag = doneFlag_q;

endmodule // adc_auto_trigger

// *** dv/adc_auto_trigger_properties.sv ***
// Concurrent checks on the ports of the converter trigger and input-disable block.
`timescale 1ns/1ps
module adc_auto_trigger_properties
  import adc_trig_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [adc_trig_pkg::ADDR_W-1:0] regAddr,
  input wire logic [adc_trig_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [adc_trig_pkg::DATA_W-1:0] regRdata,
  input wire logic comparatorFlag,
  input wire logic extInt0Flag,
  input wire logic timerCmpAFlag,
  input wire logic timerOvfFlag,
  input wire logic timerCmpBFlag,
  input wire logic pinChangeFlag,
  input wire logic [adc_trig_pkg::DIS_W-1:0] pinIn,
  input wire logic [adc_trig_pkg::DIS_W-1:0] pinRead,
  input wire logic [adc_trig_pkg::DIS_W-1:0] inputBufferOff,
  input wire logic converterEnable,
  input wire logic conversionStart,
  input wire logic conversionBusy,
  input wire logic conversionDoneFlag
);
  // ----------------------------------------------------------------
  // Shadow of the trigger settings, rebuilt from bus writes.
  // ----------------------------------------------------------------
  logic [2:0] srcQ;
  logic autoQ;
  logic selPrevQ;
  logic [7:0] flagVec;
  logic selNow;
  logic ctrlWrite;

  // Code 7 maps to a constant low so it can never look like an edge.
  assign flagVec = {1'b0, pinChangeFlag, timerCmpBFlag, timerOvfFlag, timerCmpAFlag,
                    extInt0Flag, comparatorFlag, conversionDoneFlag};
  assign selNow = flagVec[srcQ];
  assign ctrlWrite = regWrite && (regAddr == OFF_CTRL_A);

  // Source field mirror.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      srcQ <= 3'h0;
    end else if (regWrite && (regAddr == OFF_TRIG_CTRL)) begin
      srcQ <= regWdata[2:0];
    end
  end

  // Auto-trigger enable mirror.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      autoQ <= 1'b0;
    end else if (ctrlWrite) begin
      autoQ <= regWdata[CA_AUTO_BIT];
    end
  end

  // Selected flag one cycle ago, so a source switch counts as an edge.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      selPrevQ <= 1'b0;
    end else begin
      selPrevQ <= selNow;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data not zero outside read answer");
  reserved_zero_a: assert property ($past(regRead) |->
    (regRdata & (($past(regAddr) == OFF_TRIG_CTRL) ? 8'hb8 :
    ($past(regAddr) == OFF_INPUT_DIS) ? 8'hc0 : 8'h00)) == 8'h00)
    else $error("reserved bits read nonzero");
  disable_write_a: assert property (
    regWrite && regAddr == OFF_INPUT_DIS |=> inputBufferOff == $past(regWdata[5:0]))
    else $error("input buffer disable not taken from write");
  pin_mask_a: assert property (
    $past(resetn) |-> pinRead == ($past(pinIn) & ~$past(inputBufferOff)))
    else $error("port read not masked by disable bits");
  start_busy_a: assert property (conversionStart == $rose(conversionBusy))
    else $error("start pulse and busy rise disagree");
  trigger_start_a: assert property (autoQ && converterEnable && srcQ != 3'h0 &&
    selNow && !selPrevQ && !conversionBusy && !ctrlWrite |=> conversionStart)
    else $error("selected flag edge did not start conversion");
  auto_off_a: assert property (!autoQ && !ctrlWrite |=> !conversionStart)
    else $error("start while auto trigger off");
  free_switch_a: assert property (
    srcQ == 3'h0 && $past(srcQ) != 3'h0 && conversionDoneFlag && !ctrlWrite |=> !conversionStart)
    else $error("switch to free running started a conversion");
  done_set_a: assert property (
    $fell(conversionBusy) && converterEnable |-> conversionDoneFlag)
    else $error("done flag not set at conversion end");
endmodule // adc_auto_trigger_properties

// *** dv/trigger_source_model.sv ***
// Behavioural model of the trigger flag sources and the analog core result.
`timescale 1ns/1ps
module trigger_source_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [5:0] flagSet,
  input wire logic [9:0] resultValue,
  input wire logic convBusy,
  output logic [5:0] flags,
  output logic [9:0] conversionResult
);
  // ----------------------------------------------------------------
  // Flags and result.
  // ----------------------------------------------------------------
  // Flags belong to other peripherals, so they only move after a clock edge.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flags <= 6'h00;
    end else begin
      flags <= flagSet;
    end
  end

  // Outside a conversion the core output is not valid; it toggles so a badly timed sample shows.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      conversionResult <= 10'h155;
    end else if (convBusy) begin
      conversionResult <= resultValue;
    end else begin
      conversionResult <= ~conversionResult;
    end
  end
endmodule // trigger_source_model

// *** dv/adc_auto_trigger_tb.sv ***
// Self-checking testbench for the converter trigger and input-disable block.
`timescale 1ns/1ps
module adc_auto_trigger_tb;
  import adc_trig_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic [5:0] flags;
  logic [5:0] flagSet = 6'h00;
  logic [9:0] resultValue = 10'h000;
  logic [9:0] conversionResult;
  logic [5:0] pinIn = 6'h00;
  logic [5:0] pinRead;
  logic [5:0] inputBufferOff;
  logic comparatorMuxEnable;
  logic converterEnable;
  logic conversionStart;
  logic conversionBusy;
  logic conversionDoneFlag;
  logic [7:0] expQ[$];
  logic rdPend = 1'b0;
  logic seen;
  logic [7:0] dis;
  int failures = 0;
  int nTests = 0;
  int cycles = 0;
  int seed = 32'h63e73b19;

  adc_auto_trigger u_adc_auto_trigger (.mclk, .resetn, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata, .comparatorFlag(flags[0]), .extInt0Flag(flags[1]),
    .timerCmpAFlag(flags[2]), .timerOvfFlag(flags[3]), .timerCmpBFlag(flags[4]),
    .pinChangeFlag(flags[5]), .conversionResult, .pinIn, .pinRead, .inputBufferOff,
    .comparatorMuxEnable, .converterEnable, .conversionStart, .conversionBusy,
    .conversionDoneFlag);
  trigger_source_model u_trigger_source_model (.mclk, .resetn, .flagSet, .resultValue,
    .convBusy(conversionBusy), .flags, .conversionResult);

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t mismatch seen %h expected %h", $time, got, exp);
    end
  endtask

  task final_report;
    if (failures == 0 && nTests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  // The expected answer is queued here and compared by the read monitor.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge mclk);
    regRead <= 1'b0;
  endtask

  task automatic waitStart(input int lim, output logic hit);
    hit = 1'b0;
    repeat (lim) begin
      @(posedge mclk);
      #1;
      if (conversionStart === 1'b1) hit = 1'b1;
    end
  endtask

  // Bounded, and looks only after an edge so a start taken at the calling edge counts.
  task automatic waitIdle;
    for (int n = 0; n < 400; n++) begin
      @(posedge mclk);
      #1;
      if (conversionBusy === 1'b0) break;
    end
  endtask

  task automatic flagPulse(input logic [5:0] v, input logic want);
    @(posedge mclk);
    flagSet <= v;
    waitStart(8, seen);
    check({15'h0, seen}, {15'h0, want});
  endtask

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // Read data stand only in the cycle after the strobe, so compare exactly there.
  always @(posedge mclk) begin
    if (rdPend) begin
      check({8'h00, regRdata}, {8'h00, expQ.pop_front()});
    end
    rdPend <= regRead;
  end

  // Hang guard; the whole sequence needs well under two thousand cycles.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      final_report;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rd(OFF_TRIG_CTRL, 8'h00);
    rd(OFF_CTRL_A, 8'h00);
    rd(OFF_INPUT_DIS, 8'h00);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    wr(OFF_TRIG_CTRL, 8'hff);
    rd(OFF_TRIG_CTRL, 8'h47);
    check({15'h0, comparatorMuxEnable}, 16'h0001);
    wr(OFF_INPUT_DIS, 8'hff);
    rd(OFF_INPUT_DIS, 8'h3f);
    check({10'h0, inputBufferOff}, 16'h003f);
    for (int i = 0; i < 8; i++) begin
      dis = 8'($random(seed));
      wr(OFF_INPUT_DIS, dis);
      @(posedge mclk);
      pinIn <= 6'($random(seed));
      repeat (3) @(posedge mclk);
      #1;
      check({10'h0, pinRead}, {10'h0, pinIn & ~dis[5:0]});
    end
    // Every flag source, codes 1 to 6, starts a conversion on its own rising flag.
    wr(OFF_CTRL_A, 8'hb0);
    for (int s = 1; s < 7; s++) begin
      wr(OFF_TRIG_CTRL, 8'(s));
      flagPulse(6'h01 << (s - 1), 1'b1);
      @(posedge mclk);
      flagSet <= 6'h00;
      waitIdle;
      check({15'h0, conversionDoneFlag}, 16'h0001);
      wr(OFF_CTRL_A, 8'hb0);
    end
    wr(OFF_TRIG_CTRL, 8'h07);
    flagPulse(6'h3f, 1'b0);
    flagPulse(6'h00, 1'b0);
    wr(OFF_CTRL_A, 8'h90);
    wr(OFF_TRIG_CTRL, 8'h01);
    flagPulse(6'h01, 1'b0);
    // Comparator stays high; moving onto it from a low source is an edge.
    wr(OFF_TRIG_CTRL, 8'h02);
    wr(OFF_CTRL_A, 8'hb0);
    wr(OFF_TRIG_CTRL, 8'h01);
    waitStart(6, seen);
    check({15'h0, seen}, 16'h0001);
    waitIdle;
    // Old source low, so only the guard blocks the switch.
    @(posedge mclk);
    flagSet <= 6'h00;
    wr(OFF_TRIG_CTRL, 8'h00);
    waitStart(8, seen);
    check({15'h0, seen}, 16'h0000);
    @(posedge mclk);
    flagSet <= 6'h01;
    wr(OFF_CTRL_A, 8'h30);
    wr(OFF_TRIG_CTRL, 8'h02);
    wr(OFF_TRIG_CTRL, 8'h01);
    waitStart(8, seen);
    check({15'h0, seen}, 16'h0000);
    check({15'h0, converterEnable}, 16'h0000);
    @(posedge mclk);
    resultValue <= 10'($random(seed));
    wr(OFF_CTRL_A, 8'hc0);
    waitIdle;
    rd(OFF_RESULT_LO, resultValue[7:0]);
    rd(OFF_RESULT_HI, {6'h00, resultValue[9:8]});
    rd(OFF_CTRL_A, 8'h90);
    // Free running restarts on its own done flag.
    wr(OFF_TRIG_CTRL, 8'h00);
    wr(OFF_CTRL_A, 8'hf0);
    waitIdle;
    waitStart(4, seen);
    check({15'h0, seen}, 16'h0001);
    repeat (3) @(posedge mclk);
    final_report;
  end
endmodule // adc_auto_trigger_tb

bind adc_auto_trigger adc_auto_trigger_properties u_adc_auto_trigger_properties (.mclk,
  .resetn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .comparatorFlag,
  .extInt0Flag, .timerCmpAFlag, .timerOvfFlag, .timerCmpBFlag, .pinChangeFlag, .pinIn,
  .pinRead, .inputBufferOff, .converterEnable, .conversionStart, .conversionBusy,
  .conversionDoneFlag);
